// [acts_pkg.sv]
package acts_pkg;

  // Register word addresses on the plain register port
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_INPUT_MODE_LOW       = 6'h00;
  localparam logic [5:0] OFS_INPUT_MODE_HIGH      = 6'h01;
  localparam logic [5:0] OFS_CHANNEL_IRQ_ENABLE   = 6'h02;
  localparam logic [5:0] OFS_RESULT_READY_STATUS  = 6'h03;
  localparam logic [5:0] OFS_TRIGGER_SELECT_BASE  = 6'h04;
  localparam logic [5:0] OFS_TRIGGER_SELECT_LAST  = 6'h0b;
  localparam logic [5:0] OFS_LEVEL_TRIGGER_ENABLE = 6'h0c;
  localparam logic [5:0] OFS_IRQ_STATUS           = 6'h0d;
  localparam logic [5:0] OFS_IRQ_CLEAR            = 6'h0e;
  localparam logic [5:0] OFS_RESULT_BUFFER_BASE   = 6'h10;
  localparam logic [5:0] OFS_RESULT_BUFFER_LAST   = 6'h1e;

  // Geometry
  localparam int unsigned NUM_CH   = 15;
  localparam int unsigned NUM_TSEL = 16;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned TSEL_W   = 5;

  // Implemented bit masks
  localparam logic [15:0] MASK_INPUT_MODE_LOW  = 16'h555f;
  localparam logic [15:0] MASK_INPUT_MODE_HIGH = 16'h1555;
  localparam logic [15:0] MASK_CHANNEL         = 16'h7fff;
  localparam logic [15:0] MASK_TRIGGER_SELECT  = 16'h1f1f;

  // Field positions
  localparam int unsigned POS_DIFF0     = 1;
  localparam int unsigned POS_DIFF1     = 3;
  localparam int unsigned POS_TSEL_LO   = 0;
  localparam int unsigned POS_TSEL_HI   = 8;
  localparam int unsigned SIGNS_PER_REG = 8;

  // Reset values
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [4:0]  RST_TSEL  = 5'h00;

  typedef enum logic [4:0] {
    TRG_NONE         = 5'b00000,
    TRG_SW_COMMON    = 5'b00001,
    TRG_SW_LEVEL     = 5'b00010,
    TRG_PWM_SPECIAL  = 5'b00100,
    TRG_PWM1_PRI     = 5'b00101,
    TRG_PWM2_PRI     = 5'b00110,
    TRG_PWM3_PRI     = 5'b00111,
    TRG_TMR1_PERIOD  = 5'b01100,
    TRG_TMR2_PERIOD  = 5'b01101,
    TRG_PWM_SEC_SPEC = 5'b01110,
    TRG_PWM1_SEC     = 5'b01111,
    TRG_PWM2_SEC     = 5'b10000,
    TRG_PWM3_SEC     = 5'b10001,
    TRG_OC1          = 5'b10110,
    TRG_PWM1_CLIM    = 5'b11000,
    TRG_PWM2_CLIM    = 5'b11001,
    TRG_PWM3_CLIM    = 5'b11010,
    TRG_EXT31        = 5'b11111
  } acts_trg_e;

  // Trigger event sources
  typedef struct packed {
    logic       sw_common;
    logic       sw_level;
    logic       pwm_special;
    logic [2:0] pwm_primary;
    logic       timer1_period;
    logic       timer2_period;
    logic       pwm_sec_special;
    logic [2:0] pwm_secondary;
    logic       oc1;
    logic [2:0] pwm_current_limit;
    logic       external_trigger_input_31;
  } acts_trig_src_s;

  // Finished conversion from a converter core
  typedef struct packed {
    logic        valid;
    logic [3:0]  channel;
    logic [11:0] raw;
  } acts_conv_s;

endpackage

// [acts_channel_ctrl.sv]
// Operation
// - SIGN bit set gives signed results
// - DIFF bits 3,1 set channels 1,0 pseudodifferential
// - Input seven/eight become negative inputs
// - Unimplemented input-mode bits read zero
// - Enable bit gates common and individual interrupts
// - Read-only ready flag per channel
// - Two 5-bit selectors per channel pair
// - Codes 0,1,2: none, common, level software
// - Codes 4-7: PWM special and primaries
// - Codes 12-14: timers, PWM secondary special
// - Codes 15-17: PWM generator secondary triggers
// - Code 22: output compare one trigger
// - Codes 24-26: PWM current-limit triggers
// - Level enable picks level or edge trigger
`timescale 1ns/1ps
`default_nettype none

module acts_channel_ctrl #(
  parameter int unsigned RES_W = 12
) (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST,
  input  wire logic [5:0]               ADDR,
  input  wire logic [15:0]              WR_DATA,
  input  wire logic                     WR_STB,
  input  wire logic                     RD_STB,
  output logic      [15:0]              RD_DATA,
  input  wire acts_pkg::acts_trig_src_s TRIG_IN,
  input  wire acts_pkg::acts_conv_s     CONV_IN,
  output logic      [14:0]              CONV_TRIGGER,
  output logic      [14:0]              SIGNED_RESULT,
  output logic      [1:0]               PSEUDO_DIFF_SELECT,
  output logic                          CH0_NEG_ANALOG_INPUT_SEVEN,
  output logic                          CH1_NEG_ANALOG_INPUT_EIGHT,
  output logic      [14:0]              CHANNEL_IRQ,
  output logic                          IRQ
);

  localparam logic [15:0] HALF_SCALE = 16'(1 << (RES_W - 1));

  logic [15:0] input_mode_low_reg;
  logic [15:0] input_mode_high_reg;
  logic [14:0] irq_enable_reg;
  logic [14:0] level_enable_reg;
  logic [14:0] ready_reg;
  logic [14:0] ready_next;
  logic [14:0] irq_status_reg;
  logic [14:0] irq_status_next;
  logic [4:0]  tsel_reg [acts_pkg::NUM_TSEL];
  logic [15:0] result_mem [acts_pkg::NUM_CH];
  logic [14:0] sign_vec;
  logic [14:0] sel_now;
  logic [14:0] sel_prev_reg;
  logic [14:0] conv_trigger_reg;
  logic [14:0] done_vec;
  logic [14:0] buf_read_vec;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_mux;
  logic [15:0] conv_ext;
  logic [15:0] conv_fmt;
  logic [14:0] channel_irq_reg;
  logic        irq_reg;
  logic        wr_tsel;
  logic        rd_buf;
  logic [5:0]  tsel_word;
  logic [5:0]  buf_idx;
  logic [2:0]  tsel_pair;
  // Decode and intake qualifiers
  logic        wr_irq_clr;
  logic        tsel_hit;
  logic        buf_hit;
  logic        conv_take;
  logic        sign_now;

  // Selected source level for one channel
  function automatic logic pick_source(input logic [4:0] code,
                                       input acts_pkg::acts_trig_src_s s);
    logic hit;
    hit = 1'b0;
    case (code)
      acts_pkg::TRG_NONE:         hit = 1'b0;
      acts_pkg::TRG_SW_COMMON:    hit = s.sw_common;
      acts_pkg::TRG_SW_LEVEL:     hit = s.sw_level;
      acts_pkg::TRG_PWM_SPECIAL:  hit = s.pwm_special;
      acts_pkg::TRG_PWM1_PRI:     hit = s.pwm_primary[0];
      acts_pkg::TRG_PWM2_PRI:     hit = s.pwm_primary[1];
      acts_pkg::TRG_PWM3_PRI:     hit = s.pwm_primary[2];
      acts_pkg::TRG_TMR1_PERIOD:  hit = s.timer1_period;
      acts_pkg::TRG_TMR2_PERIOD:  hit = s.timer2_period;
      acts_pkg::TRG_PWM_SEC_SPEC: hit = s.pwm_sec_special;
      acts_pkg::TRG_PWM1_SEC:     hit = s.pwm_secondary[0];
      acts_pkg::TRG_PWM2_SEC:     hit = s.pwm_secondary[1];
      acts_pkg::TRG_PWM3_SEC:     hit = s.pwm_secondary[2];
      acts_pkg::TRG_OC1:          hit = s.oc1;
      acts_pkg::TRG_PWM1_CLIM:    hit = s.pwm_current_limit[0];
      acts_pkg::TRG_PWM2_CLIM:    hit = s.pwm_current_limit[1];
      acts_pkg::TRG_PWM3_CLIM:    hit = s.pwm_current_limit[2];
      acts_pkg::TRG_EXT31:        hit = s.external_trigger_input_31;
      default:                    hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Address decode
  always_comb begin
    tsel_hit   = (ADDR >= acts_pkg::OFS_TRIGGER_SELECT_BASE) &&
                 (ADDR <= acts_pkg::OFS_TRIGGER_SELECT_LAST);
    buf_hit    = (ADDR >= acts_pkg::OFS_RESULT_BUFFER_BASE) &&
                 (ADDR <= acts_pkg::OFS_RESULT_BUFFER_LAST);
    wr_tsel    = WR_STB && tsel_hit;
    rd_buf     = RD_STB && buf_hit;
    wr_irq_clr = WR_STB && (ADDR == acts_pkg::OFS_IRQ_CLEAR);
    tsel_word  = ADDR - acts_pkg::OFS_TRIGGER_SELECT_BASE;
    tsel_pair  = tsel_word[2:0];
    buf_idx    = ADDR - acts_pkg::OFS_RESULT_BUFFER_BASE;
  end

  // Input-mode registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      input_mode_low_reg  <= acts_pkg::RST_REG16;
      input_mode_high_reg <= acts_pkg::RST_REG16;
    end else if (WR_STB) begin
      if (ADDR == acts_pkg::OFS_INPUT_MODE_LOW) begin
        input_mode_low_reg <= WR_DATA & acts_pkg::MASK_INPUT_MODE_LOW;
      end
      if (ADDR == acts_pkg::OFS_INPUT_MODE_HIGH) begin
        input_mode_high_reg <= WR_DATA & acts_pkg::MASK_INPUT_MODE_HIGH;
      end
    end
  end

  // Interrupt and level enables
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_enable_reg   <= '0;
      level_enable_reg <= '0;
    end else if (WR_STB) begin
      if (ADDR == acts_pkg::OFS_CHANNEL_IRQ_ENABLE) begin
        irq_enable_reg <= WR_DATA[14:0];
      end
      if (ADDR == acts_pkg::OFS_LEVEL_TRIGGER_ENABLE) begin
        level_enable_reg <= WR_DATA[14:0];
      end
    end
  end

  // Trigger selector fields, two per word
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      for (int i = 0; i < acts_pkg::NUM_TSEL; i++) begin
        tsel_reg[i] <= acts_pkg::RST_TSEL;
      end
    end else if (wr_tsel) begin
      tsel_reg[{tsel_pair, 1'b0}] <= WR_DATA[acts_pkg::POS_TSEL_LO +: 5];
      tsel_reg[{tsel_pair, 1'b1}] <= WR_DATA[acts_pkg::POS_TSEL_HI +: 5];
    end
  end

  // Per-channel sign select, eight in the low word
  always_comb begin
    for (int i = 0; i < acts_pkg::SIGNS_PER_REG; i++) begin
      sign_vec[i] = input_mode_low_reg[2 * i];
    end
    for (int i = acts_pkg::SIGNS_PER_REG; i < acts_pkg::NUM_CH; i++) begin
      sign_vec[i] = input_mode_high_reg[2 * (i - acts_pkg::SIGNS_PER_REG)];
    end
  end

  // Trigger routing
  always_comb begin
    for (int i = 0; i < acts_pkg::NUM_CH; i++) begin
      sel_now[i] = pick_source(tsel_reg[i], TRIG_IN);
    end
  end

  // Edge or level trigger per channel
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sel_prev_reg     <= '0;
      conv_trigger_reg <= '0;
    end else begin
      sel_prev_reg <= sel_now;
      for (int i = 0; i < acts_pkg::NUM_CH; i++) begin
        if (level_enable_reg[i]) begin
          conv_trigger_reg[i] <= sel_now[i];
        end else begin
          conv_trigger_reg[i] <= sel_now[i] & ~sel_prev_reg[i];
        end
      end
    end
  end

  // Conversion formatting; channel 15 is never taken
  always_comb begin
    conv_take = CONV_IN.valid && (CONV_IN.channel < 4'(acts_pkg::NUM_CH));
    sign_now  = 1'b0;
    if (conv_take) begin
      sign_now = sign_vec[CONV_IN.channel];
    end
    conv_ext  = {{(16 - RES_W){1'b0}}, CONV_IN.raw[RES_W-1:0]};
    if (sign_now) begin
      conv_fmt = conv_ext - HALF_SCALE;
    end else begin
      conv_fmt = conv_ext;
    end
  end

  always_comb begin
    done_vec     = '0;
    buf_read_vec = '0;
    if (conv_take) begin
      done_vec[CONV_IN.channel] = 1'b1;
    end
    if (rd_buf) begin
      buf_read_vec[buf_idx[3:0]] = 1'b1;
    end
  end

  // Result buffers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      for (int i = 0; i < acts_pkg::NUM_CH; i++) begin
        result_mem[i] <= acts_pkg::RST_REG16;
      end
    end else if (conv_take) begin
      result_mem[CONV_IN.channel] <= conv_fmt;
    end
  end

  // Ready flags: completion wins over read clear
  always_comb begin
    ready_next = (ready_reg & ~buf_read_vec) | done_vec;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ready_reg <= '0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  // Sticky interrupt status
  always_comb begin
    irq_status_next = irq_status_reg | done_vec;
    if (wr_irq_clr) begin
      irq_status_next = (irq_status_reg & ~WR_DATA[14:0]) | done_vec;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_status_reg  <= '0;
      channel_irq_reg <= '0;
      irq_reg         <= 1'b0;
    end else begin
      irq_status_reg  <= irq_status_next;
      channel_irq_reg <= irq_status_reg & irq_enable_reg;
      irq_reg         <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // Read mux
  always_comb begin
    rd_mux = '0;
    case (ADDR)
      acts_pkg::OFS_INPUT_MODE_LOW:
        rd_mux = input_mode_low_reg & acts_pkg::MASK_INPUT_MODE_LOW;
      acts_pkg::OFS_INPUT_MODE_HIGH:
        rd_mux = input_mode_high_reg & acts_pkg::MASK_INPUT_MODE_HIGH;
      acts_pkg::OFS_CHANNEL_IRQ_ENABLE:
        rd_mux = {1'b0, irq_enable_reg};
      acts_pkg::OFS_RESULT_READY_STATUS:
        rd_mux = {1'b0, ready_reg};
      acts_pkg::OFS_LEVEL_TRIGGER_ENABLE:
        rd_mux = {1'b0, level_enable_reg};
      acts_pkg::OFS_IRQ_STATUS:
        rd_mux = {1'b0, irq_status_reg};
      default: begin
        if (tsel_hit) begin
          rd_mux = {3'h0, tsel_reg[{tsel_pair, 1'b1}],
                    3'h0, tsel_reg[{tsel_pair, 1'b0}]};
        end else if (buf_hit) begin
          rd_mux = result_mem[buf_idx[3:0]];
        end else begin
          rd_mux = '0;
        end
      end
    endcase
  end

  // Read data stands one cycle, else zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_data_reg <= '0;
    end else if (RD_STB) begin
      rd_data_reg <= rd_mux;
    end else begin
      rd_data_reg <= '0;
    end
  end

  // Analog front-end controls
  logic [14:0] signed_result_reg;
  logic [1:0]  pdiff_reg;
  logic        neg_seven_reg;
  logic        neg_eight_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      signed_result_reg <= '0;
      pdiff_reg         <= '0;
      neg_seven_reg     <= 1'b0;
      neg_eight_reg     <= 1'b0;
    end else begin
      signed_result_reg <= sign_vec;
      pdiff_reg         <= {input_mode_low_reg[acts_pkg::POS_DIFF1],
                            input_mode_low_reg[acts_pkg::POS_DIFF0]};
      neg_seven_reg     <= input_mode_low_reg[acts_pkg::POS_DIFF0];
      neg_eight_reg     <= input_mode_low_reg[acts_pkg::POS_DIFF1];
    end
  end

  assign RD_DATA                    = rd_data_reg;
  assign CONV_TRIGGER               = conv_trigger_reg;
  assign SIGNED_RESULT              = signed_result_reg;
  assign PSEUDO_DIFF_SELECT         = pdiff_reg;
  assign CH0_NEG_ANALOG_INPUT_SEVEN = neg_seven_reg;
  assign CH1_NEG_ANALOG_INPUT_EIGHT = neg_eight_reg;
  assign CHANNEL_IRQ                = channel_irq_reg;
  assign IRQ                        = irq_reg;

endmodule

`default_nettype wire

// [acts_channel_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module acts_channel_ctrl_chk (
  input wire logic                     CLK_SYS,
  input wire logic                     RST,
  input wire logic [5:0]               ADDR,
  input wire logic [15:0]              WR_DATA,
  input wire logic                     WR_STB,
  input wire logic                     RD_STB,
  input wire logic [15:0]              RD_DATA,
  input wire acts_pkg::acts_trig_src_s TRIG_IN,
  input wire acts_pkg::acts_conv_s     CONV_IN,
  input wire logic [14:0]              CONV_TRIGGER,
  input wire logic [14:0]              SIGNED_RESULT,
  input wire logic [1:0]               PSEUDO_DIFF_SELECT,
  input wire logic                     CH0_NEG_ANALOG_INPUT_SEVEN,
  input wire logic                     CH1_NEG_ANALOG_INPUT_EIGHT,
  input wire logic [14:0]              CHANNEL_IRQ,
  input wire logic                     IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Clear of every status bit with no conversion racing it
  sequence clr_all_s;
    WR_STB && ADDR == 6'h0e && &WR_DATA[14:0] && !CONV_IN.valid ##1 !CONV_IN.valid;
  endsequence
  // All enables cleared, then one cycle for the lagging output
  sequence en_off_s;
    WR_STB && ADDR == 6'h02 && WR_DATA == 16'h0000 ##1 1'b1;
  endsequence
  neg_seven_a: assert property (CH0_NEG_ANALOG_INPUT_SEVEN == PSEUDO_DIFF_SELECT[0])
    else $error("input seven pairing differs from channel 0 mode");
  neg_eight_a: assert property (CH1_NEG_ANALOG_INPUT_EIGHT == PSEUDO_DIFF_SELECT[1])
    else $error("input eight pairing differs from channel 1 mode");
  diff_write_a: assert property (WR_STB && ADDR == 6'h00 |-> ##2
    PSEUDO_DIFF_SELECT == {$past(WR_DATA[3], 2), $past(WR_DATA[1], 2)})
    else $error("pseudodifferential select not taken from bits 3 and 1");
  sign_write_a: assert property (WR_STB && ADDR == 6'h01 |-> ##2
    SIGNED_RESULT[14:12] == {$past(WR_DATA[12], 2), $past(WR_DATA[10], 2),
                             $past(WR_DATA[8], 2)})
    else $error("sign select not taken from even bits");
  read_idle_a: assert property (!$past(RD_STB) |-> RD_DATA == 16'h0000)
    else $error("read data present without a read");
  no_source_a: assert property ($past(TRIG_IN) == '0 && $past(TRIG_IN, 2) == '0
    |-> CONV_TRIGGER == 15'h0000)
    else $error("conversion trigger with no source active");
  irq_clear_a: assert property (clr_all_s |=> !IRQ && CHANNEL_IRQ == 15'h0000)
    else $error("interrupt stays after clearing all status");
  irq_mask_a: assert property (en_off_s |=> !IRQ && CHANNEL_IRQ == 15'h0000)
    else $error("interrupt stays with all enables off");
  irq_any_a: assert property (IRQ == |CHANNEL_IRQ)
    else $error("common interrupt differs from channel interrupts");
endmodule
`default_nettype wire

// [acts_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acts_src_model (
  input  wire logic                  clk,
  input  wire logic [4:0]            code,
  input  wire logic                  fire,
  output var acts_pkg::acts_trig_src_s src
);
  // Raise the source a code names; none or reserved raises every source
  always_ff @(posedge clk) begin
    src <= '0;
    if (fire) begin
      case (code) inside
        5'h01: src.sw_common <= 1'b1;
        5'h02: src.sw_level <= 1'b1;
        5'h04: src.pwm_special <= 1'b1;
        [5'h05:5'h07]: src.pwm_primary[code - 5'h05] <= 1'b1;
        5'h0c: src.timer1_period <= 1'b1;
        5'h0d: src.timer2_period <= 1'b1;
        5'h0e: src.pwm_sec_special <= 1'b1;
        [5'h0f:5'h11]: src.pwm_secondary[code - 5'h0f] <= 1'b1;
        5'h16: src.oc1 <= 1'b1;
        [5'h18:5'h1a]: src.pwm_current_limit[code - 5'h18] <= 1'b1;
        5'h1f: src.external_trigger_input_31 <= 1'b1;
        default: src <= '1;
      endcase
    end
  end
endmodule
`default_nettype wire

// [adc_channel_mode_trigger_select_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_channel_mode_trigger_select_tb_top;
  logic CLK_SYS, RST, WR_STB, RD_STB, CH0_NEG_ANALOG_INPUT_SEVEN, CH1_NEG_ANALOG_INPUT_EIGHT;
  logic IRQ, src_fire, v;
  logic [5:0]  ADDR;
  logic [15:0] WR_DATA, RD_DATA, d;
  logic [14:0] CONV_TRIGGER, SIGNED_RESULT, CHANNEL_IRQ, acc;
  logic [1:0]  PSEUDO_DIFF_SELECT;
  logic [4:0]  src_code;
  acts_pkg::acts_trig_src_s TRIG_IN;
  acts_pkg::acts_conv_s     CONV_IN;
  int fails, tests_run, n, i;
  acts_channel_ctrl DUT (
    .CLK_SYS                    (CLK_SYS),
    .RST                        (RST),
    .ADDR                       (ADDR),
    .WR_DATA                    (WR_DATA),
    .WR_STB                     (WR_STB),
    .RD_STB                     (RD_STB),
    .RD_DATA                    (RD_DATA),
    .TRIG_IN                    (TRIG_IN),
    .CONV_IN                    (CONV_IN),
    .CONV_TRIGGER               (CONV_TRIGGER),
    .SIGNED_RESULT              (SIGNED_RESULT),
    .PSEUDO_DIFF_SELECT         (PSEUDO_DIFF_SELECT),
    .CH0_NEG_ANALOG_INPUT_SEVEN (CH0_NEG_ANALOG_INPUT_SEVEN),
    .CH1_NEG_ANALOG_INPUT_EIGHT (CH1_NEG_ANALOG_INPUT_EIGHT),
    .CHANNEL_IRQ                (CHANNEL_IRQ),
    .IRQ                        (IRQ)
  );
  acts_src_model u_src (.clk(CLK_SYS), .code(src_code), .fire(src_fire), .src(TRIG_IN));
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] dv);
    @(posedge CLK_SYS);
    WR_STB  <= 1'b1;
    ADDR    <= a;
    WR_DATA <= dv;
    @(posedge CLK_SYS);
    WR_STB  <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge CLK_SYS);
    RD_STB <= 1'b1;
    ADDR   <= a;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1 chk($sformatf("reg %h", a), RD_DATA, e);
  endtask
  // Hold a source for three cycles, gather the triggers it causes
  task automatic fire(input logic [4:0] c);
    acc = '0;
    n = 0;
    @(posedge CLK_SYS);
    src_code <= c;
    src_fire <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      @(posedge CLK_SYS);
      if (k == 2) src_fire <= 1'b0;
      #1 acc |= CONV_TRIGGER;
      if (CONV_TRIGGER !== 15'h0000) n++;
    end
  endtask
  task automatic conv(input logic [3:0] ch, input logic [11:0] raw);
    @(posedge CLK_SYS);
    CONV_IN <= '{1'b1, ch, raw};
    @(posedge CLK_SYS);
    CONV_IN <= '0;
  endtask
  task automatic results;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [15:0] all_ones(input int a);
    case (a)
      0: return 16'h555f;
      1: return 16'h1555;
      2, 12: return 16'h7fff;
      3: return 16'h0000;
      default: return 16'h1f1f;
    endcase
  endfunction
  initial begin
    #60000;
    fails++;
    results;
  end
  initial begin
    RST = 1'b1;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    ADDR = '0;
    WR_DATA = '0;
    CONV_IN = '0;
    src_fire = 1'b0;
    src_code = '0;
    fails = 0;
    tests_run = 0;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (i = 0; i < 32; i++) rd(6'(i), 16'h0000);
    for (i = 0; i < 13; i++) wr(6'(i), 16'hffff);
    for (i = 0; i < 13; i++) rd(6'(i), all_ones(i));
    chk("diff", 16'(PSEUDO_DIFF_SELECT), 16'h0003);
    chk("neg", {14'h0, CH1_NEG_ANALOG_INPUT_EIGHT, CH0_NEG_ANALOG_INPUT_SEVEN}, 16'h0003);
    chk("sign", 16'(SIGNED_RESULT), 16'h7fff);
    for (i = 0; i < 13; i++) wr(6'(i), 16'h0000);
    chk("neg off", {14'h0, CH1_NEG_ANALOG_INPUT_EIGHT, CH0_NEG_ANALOG_INPUT_SEVEN}, 16'h0);
    for (i = 0; i < 32; i++) begin
      wr(6'h04, 16'(i));
      fire(5'(i));
      v = 5'(i) inside {5'h01, 5'h02, [5'h04:5'h07], [5'h0c:5'h11], 5'h16, [5'h18:5'h1a], 5'h1f};
      chk($sformatf("code %0d", i), 16'(acc), v ? 16'h0001 : 16'h0000);
      chk("edge count", 16'(n), v ? 16'h0001 : 16'h0000);
    end
    wr(6'h04, 16'h0000);
    wr(6'h0c, 16'h2aaa);
    for (i = 0; i < 15; i++) begin
      d = 16'(6'h04 + 2 * (i / 4) + ((i % 4) >= 2));
      wr(d[5:0], i[0] ? 16'h0100 : 16'h0001);
      fire(5'h01);
      chk($sformatf("chan %0d", i), 16'(acc), 16'(15'h1 << i));
      chk("mode count", 16'(n), i[0] ? 16'h0003 : 16'h0001);
      wr(d[5:0], 16'h0000);
    end
    wr(6'h00, 16'h0040);
    wr(6'h02, 16'h0008);
    conv(4'h3, 12'h000);
    conv(4'h2, 12'habc);
    conv(4'hf, 12'h123);
    rd(6'h03, 16'h000c);
    chk("irq", {CHANNEL_IRQ, IRQ}, 16'h0011);
    rd(6'h0d, 16'h000c);
    rd(6'h13, 16'hf800);
    rd(6'h12, 16'h0abc);
    rd(6'h03, 16'h0000);
    chk("irq sticky", 16'(IRQ), 16'h0001);
    wr(6'h0e, 16'h7fff);
    repeat (2) @(posedge CLK_SYS);
    #1 chk("irq cleared", 16'(IRQ), 16'h0000);
    results;
  end
endmodule
bind acts_channel_ctrl acts_channel_ctrl_chk u_chk (
  .CLK_SYS                    (CLK_SYS),
  .RST                        (RST),
  .ADDR                       (ADDR),
  .WR_DATA                    (WR_DATA),
  .WR_STB                     (WR_STB),
  .RD_STB                     (RD_STB),
  .RD_DATA                    (RD_DATA),
  .TRIG_IN                    (TRIG_IN),
  .CONV_IN                    (CONV_IN),
  .CONV_TRIGGER               (CONV_TRIGGER),
  .SIGNED_RESULT              (SIGNED_RESULT),
  .PSEUDO_DIFF_SELECT         (PSEUDO_DIFF_SELECT),
  .CH0_NEG_ANALOG_INPUT_SEVEN (CH0_NEG_ANALOG_INPUT_SEVEN),
  .CH1_NEG_ANALOG_INPUT_EIGHT (CH1_NEG_ANALOG_INPUT_EIGHT),
  .CHANNEL_IRQ                (CHANNEL_IRQ),
  .IRQ                        (IRQ)
);
`default_nettype wire
